/* hw/acg_clock_gen.sv */
/*
 * Audio clock generator: converter master clock and auxiliary pin clock as clock enables.
 * Assumes the external master clock and bit clock arrive as pins sampled by the system clock,
 * and that the host writes the control register over the byte-wide register port.
 */
// Overview of operation
// - Converter master clock runs at 256 times the reference sample rate.
// - External master clock 512 kHz to 50 MHz goes through divider or PLL.
// - Without PLL, sample rate is divider source over 128 times Q, Q 2..17.
// - Register 0x66 bits 7:6 pick master clock or bit clock as divider source.
// - With PLL, rate is source times K times R over 2048 times P.
// - Multiplier K is integer 1..63 plus four decimal fraction digits.
// - Register 0x66 bits 5:4 pick master clock or bit clock as PLL source.
// - With output select 0, pin clock is source times 2KR over MNP.
// - With output select 1, pin clock is divider source times 2 over MN.
// - Output divider M is 1, 2, 4 or 8; N is 2..17.
// - PLL cannot run only for the pin clock; when it is enabled the converters use it too.
`include "acg_defines.svh"

module acg_clock_gen
  import acg_pkg::*;
#(
  parameter int ACC_W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_mclk,
  input wire logic i_bclk,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_pll_en,
  input wire logic [3:0] i_pll_p_m1,
  input wire logic [3:0] i_pll_r_m1,
  input wire logic [5:0] i_pll_j,
  input wire logic [13:0] i_pll_d,
  input wire logic [4:0] i_div_q,
  input wire logic [1:0] i_out_m_sel,
  input wire logic [4:0] i_out_n,
  input wire logic i_out_clock_source_sel,
  output logic o_conv_mclk_en,
  output logic o_aux_pin_one_en,
  output logic o_settings_busy
);

  // --------------------------------------------------------------------------
  // Pin synchronisers and source edge detection
  // --------------------------------------------------------------------------
  logic [1:0] mclk_sync_r, bclk_sync_r;
  logic mclk_d_r, bclk_d_r;
  logic mclk_rise, bclk_rise, mclk_fall, bclk_fall;

  // Two flops per pin, then a third flop for the edge detector.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mclk_sync_r <= 2'b00;
      bclk_sync_r <= 2'b00;
      mclk_d_r <= 1'b0;
      bclk_d_r <= 1'b0;
    end else begin
      mclk_sync_r <= {mclk_sync_r[0], i_mclk};
      bclk_sync_r <= {bclk_sync_r[0], i_bclk};
      mclk_d_r <= mclk_sync_r[1];
      bclk_d_r <= bclk_sync_r[1];
    end
  end

  // One-cycle enables on each rising and each falling source edge.
  assign mclk_rise = mclk_sync_r[1] & ~mclk_d_r;
  assign bclk_rise = bclk_sync_r[1] & ~bclk_d_r;
  assign mclk_fall = ~mclk_sync_r[1] & mclk_d_r;
  assign bclk_fall = ~bclk_sync_r[1] & bclk_d_r;

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  logic [7:0] src_sel_r;

  // Host writes land here; the live copies below follow only at switchover.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      src_sel_r <= `ACG_CLK_SRC_SEL_RESET;
    end else if (i_reg_wr && i_reg_addr == `ACG_CLK_SRC_SEL_OFFSET) begin
      src_sel_r <= i_reg_wdata;
    end
  end

  // Read returns the register at its offset, zero elsewhere.
  always_comb begin
    if (i_reg_addr == `ACG_CLK_SRC_SEL_OFFSET) begin
      o_reg_rdata = src_sel_r;
    end else begin
      o_reg_rdata = 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Glitch-free switchover of all settings
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sel;
    logic pll_en;
    logic [3:0] p_m1;
    logic [3:0] r_m1;
    logic [5:0] j;
    logic [13:0] d;
    logic [4:0] q;
    logic [1:0] m_sel;
    logic [4:0] n;
    logic out_sel;
  } acg_cfg_t;

  acg_cfg_t req_cfg, cfg_r;
  acg_sw_state_t sw_state_r;
  logic conv_phase_r;
  logic phase_set;

  always_comb begin
    req_cfg.sel = src_sel_r;
    req_cfg.pll_en = i_pll_en;
    req_cfg.p_m1 = i_pll_p_m1;
    req_cfg.r_m1 = i_pll_r_m1;
    req_cfg.j = i_pll_j;
    req_cfg.d = i_pll_d;
    req_cfg.q = i_div_q;
    req_cfg.m_sel = i_out_m_sel;
    req_cfg.n = i_out_n;
    req_cfg.out_sel = i_out_clock_source_sel;
  end

  // A change waits until the converter clock is in its low phase with no rise
  // due in that cycle, then the counters restart from zero so no shortened
  // high pulse can appear.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sw_state_r <= ACG_LOAD;
      cfg_r <= '0;
    end else begin
      case (sw_state_r)
        ACG_RUN: begin
          if (req_cfg != cfg_r) begin
            sw_state_r <= ACG_DRAIN;
          end
        end
        ACG_DRAIN: begin
          if (!conv_phase_r && !phase_set) begin
            sw_state_r <= ACG_LOAD;
          end
        end
        default: begin
          cfg_r <= req_cfg;
          sw_state_r <= ACG_RUN;
        end
      endcase
    end
  end

  logic sw_load;
  assign sw_load = (sw_state_r == ACG_LOAD);
  assign o_settings_busy = (sw_state_r != ACG_RUN);

  // --------------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------------
  logic div_src_tick, div_src_edge, pll_src_tick;

  // Low bit of each field: 0 master clock, 1 bit clock.
  assign div_src_tick = cfg_r.sel[`ACG_DIV_SRC_LSB] ? bclk_rise : mclk_rise;
  assign pll_src_tick = cfg_r.sel[`ACG_PLL_SRC_LSB] ? bclk_rise : mclk_rise;

  // The converter divider counts edges of both kinds, as 256 Fsref is twice src over Q.
  assign div_src_edge = cfg_r.sel[`ACG_DIV_SRC_LSB] ? (bclk_rise | bclk_fall) :
                        (mclk_rise | mclk_fall);

  // --------------------------------------------------------------------------
  // Integer divider path: 256 Fsref = src * 2 / Q
  // --------------------------------------------------------------------------
  logic [4:0] q_cnt_r;
  logic div_tick, div_half;
  logic [4:0] q_eff;

  // Q outside 2..17 is clamped so the counter always wraps.
  assign q_eff = (cfg_r.q < `ACG_Q_MIN) ? `ACG_Q_MIN :
                 (cfg_r.q > `ACG_Q_MAX) ? `ACG_Q_MAX : cfg_r.q;

  // Src/(128 Q) is Fsref, so one 256 Fsref period is Q source edges of either
  // kind; the wrap starts the high phase and the edge at half the count ends it.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || sw_load) begin
      q_cnt_r <= 5'h00;
    end else if (div_src_edge) begin
      q_cnt_r <= (q_cnt_r == q_eff - 5'h01) ? 5'h00 : q_cnt_r + 5'h01;
    end
  end
  assign div_tick = div_src_edge && (q_cnt_r == q_eff - 5'h01);
  assign div_half = div_src_edge && (q_cnt_r == (q_eff >> 1) - 5'h01);

  // --------------------------------------------------------------------------
  // Fractional PLL path as a phase accumulator
  // --------------------------------------------------------------------------
  // 256 Fsref = src * K * R / (8 P) with K = J + D/10000; the accumulator adds
  // (10000 J + D) * R per source edge and wraps at 8 * P * 10000.
  localparam logic [ACC_W-1:0] D_SCALE = ACC_W'(`ACG_D_SCALE);
  logic [ACC_W-1:0] acc_r, k_step, acc_mod, acc_sum;
  logic pll_tick, pll_half;

  always_comb begin
    k_step = ACC_W'((D_SCALE * ACC_W'(cfg_r.j) + ACC_W'(cfg_r.d)) * ACC_W'({1'b0, cfg_r.r_m1} + 5'h01));
    acc_mod = ACC_W'(ACC_W'(`ACG_PLL_DIV_RATIO / `ACG_MCLK_RATIO) * D_SCALE
                     * ACC_W'({1'b0, cfg_r.p_m1} + 5'h01));
    acc_sum = acc_r + k_step;
  end

  // The PLL runs whenever it is enabled, and then it also drives the converter clock.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || sw_load || !cfg_r.pll_en) begin
      acc_r <= '0;
    end else if (pll_src_tick) begin
      acc_r <= (acc_sum >= acc_mod) ? acc_sum - acc_mod : acc_sum;
    end
  end
  // Each wrap is a full 256 Fsref period; the half marks its midpoint.
  assign pll_tick = cfg_r.pll_en && pll_src_tick && (acc_sum >= acc_mod);
  assign pll_half = cfg_r.pll_en && pll_src_tick && (acc_r < (acc_mod >> 1))
                    && (acc_sum >= (acc_mod >> 1)) && (acc_sum < acc_mod);

  // A rise of the converter phase due this cycle holds off a switchover.
  assign phase_set = cfg_r.pll_en ? pll_tick : div_tick;

  // --------------------------------------------------------------------------
  // Converter master clock
  // --------------------------------------------------------------------------
  // Both paths set the phase at the start of a period and clear it at the
  // midpoint. The enable pulses at each rising phase.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || sw_load) begin
      conv_phase_r <= 1'b0;
      o_conv_mclk_en <= 1'b0;
    end else if (cfg_r.pll_en) begin
      if (pll_tick) begin
        conv_phase_r <= 1'b1;
      end else if (pll_half) begin
        conv_phase_r <= 1'b0;
      end
      o_conv_mclk_en <= pll_tick;
    end else begin
      if (div_tick) begin
        conv_phase_r <= 1'b1;
      end else if (div_half) begin
        conv_phase_r <= 1'b0;
      end
      o_conv_mclk_en <= div_tick;
    end
  end

  // --------------------------------------------------------------------------
  // Auxiliary pin clock output divider
  // --------------------------------------------------------------------------
  // A rate accumulator: each source edge adds the pin clock ticks that edge is
  // worth, on the PLL path scaled by 10000 so the fraction stays exact, and each
  // cycle that holds a full divisor gives one pulse. The pin clock may outrun its
  // source, but no more than one pulse per system cycle between source edges.
  logic aux_src_tick, aux_due;
  logic [ACC_W-1:0] aux_acc_r, aux_step, aux_mod;
  logic [7:0] mn_total;
  logic [4:0] n_eff;

  assign n_eff = (cfg_r.n < `ACG_N_MIN) ? `ACG_N_MIN :
                 (cfg_r.n > `ACG_N_MAX) ? `ACG_N_MAX : cfg_r.n;
  assign mn_total = 8'({3'b000, n_eff} << cfg_r.m_sel);

  // Select 1: divider source times 2 over M N; select 0: PLL source times
  // 2 K R over M N P.
  always_comb begin
    if (cfg_r.out_sel) begin
      aux_src_tick = div_src_tick;
      aux_step = ACC_W'(32'h0000_0002);
      aux_mod = ACC_W'(mn_total);
    end else begin
      aux_src_tick = cfg_r.pll_en && pll_src_tick;
      aux_step = k_step << 1;
      aux_mod = ACC_W'(D_SCALE * ACC_W'({1'b0, cfg_r.p_m1} + 5'h01) * ACC_W'(mn_total));
    end
  end
  assign aux_due = (aux_acc_r >= aux_mod);

  // Add on each source edge, drain one divisor per pulse.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || sw_load) begin
      aux_acc_r <= '0;
      o_aux_pin_one_en <= 1'b0;
    end else begin
      aux_acc_r <= aux_acc_r + (aux_src_tick ? aux_step : '0)
                   - (aux_due ? aux_mod : '0);
      o_aux_pin_one_en <= aux_due;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_write_sel;
    i_reg_wr && i_reg_addr == `ACG_CLK_SRC_SEL_OFFSET;
  endsequence

  property p_reg_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_write_sel |=> src_sel_r == $past(i_reg_wdata);
  endproperty
  a_reg_write: assert property (p_reg_write) else $error("Select register not written.");

  property p_no_runt;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    sw_load |-> !conv_phase_r;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("Settings loaded during high phase.");

  property p_div_pulse;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (!cfg_r.pll_en && !sw_load && div_tick && !conv_phase_r) |=> o_conv_mclk_en;
  endproperty
  a_div_pulse: assert property (p_div_pulse) else $error("Divider edge missed.");

  property p_pll_pulse;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (cfg_r.pll_en && !sw_load && pll_tick) |=> o_conv_mclk_en && conv_phase_r;
  endproperty
  a_pll_pulse: assert property (p_pll_pulse) else $error("PLL wrap missed.");

  property p_pll_off;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !cfg_r.pll_en |=> acc_r == '0;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("Accumulator runs with PLL off.");

  property p_aux_count;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !sw_load |-> aux_acc_r < aux_mod + aux_step;
  endproperty
  a_aux_count: assert property (p_aux_count) else $error("Pin clock pulses fell behind.");

  property p_q_range;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    q_eff >= `ACG_Q_MIN && q_eff <= `ACG_Q_MAX && q_cnt_r < q_eff;
  endproperty
  a_q_range: assert property (p_q_range) else $error("Divider ratio out of range.");

  property p_busy_bound;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_settings_busy) |-> ##[1:200] !o_settings_busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("Switchover stalled.");

endmodule // acg_clock_gen

/* hw/acg_defines.svh */
/*
 * Register offsets, field positions, reset values and divider limits of the audio clock generator.
 * Assumes inclusion by bare name from the top module and the test bench.
 */
`ifndef ACG_DEFINES_SVH
`define ACG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ACG_CLK_SRC_SEL_OFFSET 8'h66
`define ACG_CLK_SRC_SEL_RESET 8'h00
`define ACG_DIV_SRC_MSB 7
`define ACG_DIV_SRC_LSB 6
`define ACG_PLL_SRC_MSB 5
`define ACG_PLL_SRC_LSB 4

// ----------------------------------------------------------------------------
// Fixed ratios and limits
// ----------------------------------------------------------------------------
`define ACG_MCLK_RATIO 256
`define ACG_FS_DIV_RATIO 128
`define ACG_PLL_DIV_RATIO 2048
`define ACG_Q_MIN 5'h02
`define ACG_Q_MAX 5'h11
`define ACG_N_MIN 5'h02
`define ACG_N_MAX 5'h11
`define ACG_J_MAX 6'h3f
`define ACG_D_MAX 14'h270f
`define ACG_D_SCALE 10000

`endif

/* hw/acg_pkg.sv */
/*
 * Types shared by the audio clock generator.
 * Assumes the defines header is on the include path.
 */
package acg_pkg;
  // Two-bit clock source selector; only the low bit picks the source.
  typedef logic [1:0] acg_src_t;

  // Switchover sequencer states.
  typedef enum logic [1:0] {
    ACG_RUN,
    ACG_DRAIN,
    ACG_LOAD
  } acg_sw_state_t;
endpackage

/* testbench/acg_host_clocks.sv */
/*
 * Host-side clock sources: free-running master clock and bit clock pins.
 * Assumes the bench supplies both half periods in nanoseconds.
 */
module acg_host_clocks (
  input wire logic [15:0] i_mclk_half,
  input wire logic [15:0] i_bclk_half,
  output logic o_mclk,
  output logic o_bclk
);
  timeunit 1ns;
  timeprecision 1ps;

  // Master clock never stops, so every settings switchover on it can finish unless the PLL is on with K R of 8 P or more.
  initial begin
    o_mclk = 1'b0;
    forever #(i_mclk_half) o_mclk = ~o_mclk;
  end

  // Bit clock runs free at its own, unrelated rate.
  initial begin
    o_bclk = 1'b0;
    forever #(i_bclk_half) o_bclk = ~o_bclk;
  end
endmodule // acg_host_clocks

/* testbench/audio_clock_generator_test.sv */
/*
 * Self-checking bench: counts source edges and clock-enable pulses against a rate model.
 * Assumes the clock generator design and the host clock model are compiled first.
 */
`include "acg_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module audio_clock_generator_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, mclk, bclk, reg_wr, pll_en, out_sel, conv_en, aux_en, busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] pll_p_m1, pll_r_m1;
  logic [5:0] pll_j;
  logic [13:0] pll_d;
  logic [4:0] div_q, out_n;
  logic [1:0] out_m_sel;
  logic mclk_q = 1'b0;
  logic bclk_q = 1'b0;
  logic [31:0] seed = 32'hf0c2_b1f7;
  int mclk_e = 0, bclk_e = 0, conv_n = 0, aux_n = 0, cycles = 0;
  int miscompares = 0, check_count = 0;

  acg_host_clocks i_acg_host_clocks (.i_mclk_half(16'h0028), .i_bclk_half(16'h0037),
    .o_mclk(mclk), .o_bclk(bclk));
  acg_clock_gen i_acg_clock_gen (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_mclk(mclk),
    .i_bclk(bclk), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .i_pll_en(pll_en), .i_pll_p_m1(pll_p_m1),
    .i_pll_r_m1(pll_r_m1), .i_pll_j(pll_j), .i_pll_d(pll_d), .i_div_q(div_q),
    .i_out_m_sel(out_m_sel), .i_out_n(out_n), .i_out_clock_source_sel(out_sel),
    .o_conv_mclk_en(conv_en), .o_aux_pin_one_en(aux_en), .o_settings_busy(busy));

  // System clock at 200 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Xorshift generator for random divider settings.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Gives the model's count when the measured one lies within one of it, else the measured one.
  function automatic longint near(input longint g, input longint e);
    return (g >= e - 1 && g <= e + 1) ? e : g;
  endfunction

  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Edge and pulse counters sampled like the design samples its pins; also the hang guard.
  always @(posedge sys_clk) begin
    mclk_q <= mclk;
    bclk_q <= bclk;
    mclk_e <= mclk_e + int'(mclk && !mclk_q);
    bclk_e <= bclk_e + int'(bclk && !bclk_q);
    conv_n <= conv_n + int'(conv_en === 1'b1);
    aux_n <= aux_n + int'(aux_en === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // Applies one setup, waits out the switchover, then counts pulses over 300 source edges.
  task automatic run_case(input int pll, p, r, j, d, q, ms, n, os, input logic [7:0] rv);
    int k, c0, a0, cs0, as0, as;
    longint ec, ea;
    logic cb, ab;
    wr(`ACG_CLK_SRC_SEL_OFFSET, rv);
    pll_en = pll[0];
    pll_p_m1 = 4'(p - 1);
    pll_r_m1 = 4'(r - 1);
    pll_j = 6'(j);
    pll_d = 14'(d);
    div_q = 5'(q);
    out_m_sel = 2'(ms);
    out_n = 5'(n);
    out_sel = os[0];
    repeat (4) @(negedge sys_clk);
    for (k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    cb = pll ? rv[`ACG_PLL_SRC_LSB] : rv[`ACG_DIV_SRC_LSB];
    ab = os ? rv[`ACG_DIV_SRC_LSB] : rv[`ACG_PLL_SRC_LSB];
    c0 = conv_n;
    a0 = aux_n;
    cs0 = cb ? bclk_e : mclk_e;
    as0 = ab ? bclk_e : mclk_e;
    while ((cb ? bclk_e : mclk_e) - cs0 < 300) @(negedge sys_clk);
    as = (ab ? bclk_e : mclk_e) - as0;
    ec = pll ? 300 * (10000 * j + d) * r / (80000 * p) : 600 / q;
    ea = os ? 2 * as / ((1 << ms) * n) :
      2 * as * (10000 * j + d) * r / (10000 * p * (1 << ms) * n);
    `CHK(near(conv_n - c0, ec), ec)
    `CHK(near(aux_n - a0, ea), ea)
  endtask

  initial begin
    {rst_n, reg_wr, pll_en, out_sel} = 4'h0;
    {reg_addr, reg_wdata, pll_p_m1, pll_r_m1, pll_j, pll_d} = '0;
    {div_q, out_n, out_m_sel} = {5'h02, 5'h02, 2'h0};
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    rd(8'h66, 8'h00);
    wr(8'h65, 8'hff);
    rd(8'h65, 8'h00);
    rd(8'h66, 8'h00);
    wr(8'h66, 8'hd0);
    repeat (2) @(negedge sys_clk);
    `CHK(busy, 1'b1)
    rd(8'h66, 8'hd0);
    // Divider and PLL setups kept within the host's legal ranges.
    run_case(0, 1, 1, 1, 0, 2, 0, 17, 1, 8'h00);
    run_case(0, 1, 1, 1, 0, 17, 3, 2, 1, 8'h40);
    run_case(1, 1, 1, 4, 5000, 2, 3, 2, 0, 8'h00);
    run_case(1, 4, 2, 7, 0, 2, 2, 3, 0, 8'h40);
    run_case(1, 8, 1, 8, 1920, 5, 2, 2, 1, 8'h10);
    repeat (2) begin
      run_case(0, 1, 1, 1, 0, 2 + int'(xs() % 16), int'(xs() % 4), 2 + int'(xs() % 16), 1,
        8'(xs()));
    end
    print_verdict();
  end
endmodule // audio_clock_generator_test
